// >>> hw/sea_pkg.sv
package sea_pkg;
  typedef struct packed {
    logic valid;
    logic [17:0] y;
    logic [3:0] x;
    logic ind;
    logic [35:0] idx_val;
    logic [11:0] pc_sec;
    logic [17:0] pc_loc;
    logic remote;
    logic [11:0] fetch_sec;
    logic jump_save;
  } sea_req_t;

  typedef struct packed {
    logic [11:0] sec;
    logic [17:0] loc;
  } sea_addr_t;

  typedef struct packed {
    logic valid;
    sea_addr_t ea;
    logic is_ac;
    logic local_ea;
    logic jump_save;
    sea_addr_t save_pc;
  } sea_res_t;

  typedef enum logic [3:0] {
    SEA_IDLE = 4'b0001,
    SEA_IND = 4'b0010,
    SEA_ACC = 4'b0100,
    SEA_DONE = 4'b1000
  } sea_state_t;
endpackage : sea_pkg

// >>> hw/sea_regs.svh
`ifndef SEA_REGS_SVH
`define SEA_REGS_SVH
// Address geometry
`define SEA_SEC_W 12
`define SEA_LOC_W 18
`define SEA_WORD_W 36
// Highest in-section location that maps onto the accumulator block
`define SEA_AC_TOP 18'h0000f
// Word bit n sits at vector index 35-n
`define SEA_FMT_BIT 35
`define SEA_GLOB_IND_BIT 34
`define SEA_GLOB_X_HI 33
`define SEA_GLOB_X_LO 30
`define SEA_GLOB_A_HI 29
`define SEA_LIW_IND_BIT 22
`define SEA_LIW_X_HI 21
`define SEA_LIW_X_LO 18
// Left-half section field of an index register
`define SEA_IDX_SEC_HI 29
`define SEA_IDX_SEC_LO 18
`endif

// >>> hw/sea_unit.sv
`timescale 1ns/10ps
`include "sea_regs.svh"
// Function
// - Local indexing adds modulo section size and keeps the current section.
// - Local wrap past section top lands on accumulators, then location 20.
// - Global indexing adds address field to index register bits 6-35 only.
// - Global result with zero location is memory, never an accumulator.
// - Global addition carries and borrows across section boundaries.
// - Local indirect word address resolves in the current section.
// - Global indirect word names section and location, ignoring PC section.
// - Remotely executed instruction resolves local addresses in its fetch section.
// - Remote subroutine jump saves executing section and location plus one.
// - Global indirect word: index number bits 2-5, address bits 6-35.
// - Global indexing uses index register bits 6-35 as offset.
module sea_unit (
  input wire logic clk,
  input wire logic rst,
  input wire sea_pkg::sea_req_t req,
  output logic busy,
  output logic mem_rd,
  output sea_pkg::sea_addr_t mem_addr,
  input wire logic mem_ack,
  input wire logic [35:0] mem_data,
  output logic acc_rd,
  output logic [3:0] acc_num,
  input wire logic [35:0] acc_data,
  output sea_pkg::sea_res_t res
);
  sea_pkg::sea_state_t state_q, state_d;
  logic [11:0] base_q, base_d;
  logic [17:0] py_q, py_d;
  logic [29:0] pg_q, pg_d;
  logic pglob_q, pglob_d;
  logic pind_q, pind_d;
  logic jsave_q, jsave_d;
  sea_pkg::sea_addr_t save_q, save_d;
  logic mem_rd_q, mem_rd_d;
  sea_pkg::sea_addr_t mem_addr_q, mem_addr_d;
  logic acc_rd_q, acc_rd_d;
  logic [3:0] acc_num_q, acc_num_d;
  sea_pkg::sea_res_t res_q, res_d;
  logic busy_q, busy_d;

  // Index register is global when not a loop count and its section field is set
  function automatic logic idx_global(input logic [35:0] v);
    idx_global = !v[`SEA_FMT_BIT] && (v[`SEA_IDX_SEC_HI:`SEA_IDX_SEC_LO] != 12'h000);
  endfunction : idx_global

  function automatic sea_pkg::sea_addr_t idx_add(input logic [11:0] sec,
      input logic [17:0] y, input logic [35:0] v);
    sea_pkg::sea_addr_t a;
    a = '0;
    if (idx_global(v))
    begin
      a = v[29:0] + {{12{y[17]}}, y};
    end
    else
    begin
      a.sec = sec;
      a.loc = y + v[17:0];
    end
    idx_add = a;
  endfunction : idx_add

  sea_pkg::sea_addr_t ea_w;
  logic ea_loc_w, ind_w, fin_w;

  always_comb
  begin
    state_d = state_q;
    base_d = base_q;
    py_d = py_q;
    pg_d = pg_q;
    pglob_d = pglob_q;
    pind_d = pind_q;
    jsave_d = jsave_q;
    save_d = save_q;
    mem_rd_d = 1'b0;
    mem_addr_d = mem_addr_q;
    acc_rd_d = 1'b0;
    acc_num_d = acc_num_q;
    res_d = res_q;
    res_d.valid = 1'b0;
    ea_w = '0;
    ea_loc_w = 1'b1;
    ind_w = 1'b0;
    fin_w = 1'b0;
    case (state_q)
      sea_pkg::SEA_IDLE:
      begin
        if (req.valid)
        begin
          base_d = req.remote ? req.fetch_sec : req.pc_sec;
          jsave_d = req.jump_save;
          // Saved PC always belongs to the executing instruction
          save_d.sec = req.pc_sec;
          save_d.loc = req.pc_loc + 18'h00001;
          if (req.x != 4'h0)
          begin
            ea_w = idx_add(req.remote ? req.fetch_sec : req.pc_sec, req.y, req.idx_val);
            ea_loc_w = !idx_global(req.idx_val);
          end
          else
          begin
            ea_w.sec = req.remote ? req.fetch_sec : req.pc_sec;
            ea_w.loc = req.y;
          end
          ind_w = req.ind;
          fin_w = 1'b1;
        end
      end
      sea_pkg::SEA_IND:
      begin
        if (mem_ack)
        begin
          if (mem_data[`SEA_FMT_BIT])
          begin
            py_d = mem_data[17:0];
            pglob_d = 1'b0;
            pind_d = mem_data[`SEA_LIW_IND_BIT];
            acc_num_d = mem_data[`SEA_LIW_X_HI:`SEA_LIW_X_LO];
            ea_w.sec = base_q;
            ea_w.loc = mem_data[17:0];
          end
          else
          begin
            pg_d = mem_data[`SEA_GLOB_A_HI:0];
            pglob_d = 1'b1;
            pind_d = mem_data[`SEA_GLOB_IND_BIT];
            acc_num_d = mem_data[`SEA_GLOB_X_HI:`SEA_GLOB_X_LO];
            ea_w = mem_data[`SEA_GLOB_A_HI:0];
            ea_loc_w = 1'b0;
          end
          ind_w = pind_d;
          if (acc_num_d != 4'h0)
          begin
            acc_rd_d = 1'b1;
            state_d = sea_pkg::SEA_ACC;
          end
          else
          begin
            fin_w = 1'b1;
          end
        end
      end
      sea_pkg::SEA_ACC:
      begin
        if (pglob_q)
        begin
          ea_w = pg_q + acc_data[29:0];
          ea_loc_w = 1'b0;
        end
        else
        begin
          ea_w = idx_add(base_q, py_q, acc_data);
          ea_loc_w = !idx_global(acc_data);
        end
        ind_w = pind_q;
        fin_w = 1'b1;
      end
      sea_pkg::SEA_DONE:
      begin
        state_d = sea_pkg::SEA_IDLE;
      end
      default:
      begin
        state_d = sea_pkg::SEA_IDLE;
      end
    endcase
    if (fin_w)
    begin
      if (ind_w)
      begin
        mem_rd_d = 1'b1;
        mem_addr_d = ea_w;
        state_d = sea_pkg::SEA_IND;
      end
      else
      begin
        res_d.valid = 1'b1;
        res_d.ea = ea_w;
        res_d.local_ea = ea_loc_w;
        // Only local results can reach the fast registers
        res_d.is_ac = ea_loc_w && (ea_w.loc <= `SEA_AC_TOP);
        res_d.jump_save = jsave_d;
        res_d.save_pc = save_d;
        state_d = sea_pkg::SEA_DONE;
      end
    end
    busy_d = (state_d != sea_pkg::SEA_IDLE);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= sea_pkg::SEA_IDLE;
      base_q <= 12'h000;
      py_q <= 18'h00000;
      pg_q <= 30'h00000000;
      pglob_q <= 1'b0;
      pind_q <= 1'b0;
      jsave_q <= 1'b0;
      save_q <= '0;
      mem_rd_q <= 1'b0;
      mem_addr_q <= '0;
      acc_rd_q <= 1'b0;
      acc_num_q <= 4'h0;
      res_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      base_q <= base_d;
      py_q <= py_d;
      pg_q <= pg_d;
      pglob_q <= pglob_d;
      pind_q <= pind_d;
      jsave_q <= jsave_d;
      save_q <= save_d;
      mem_rd_q <= mem_rd_d;
      mem_addr_q <= mem_addr_d;
      acc_rd_q <= acc_rd_d;
      acc_num_q <= acc_num_d;
      res_q <= res_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;
  assign mem_rd = mem_rd_q;
  assign mem_addr = mem_addr_q;
  assign acc_rd = acc_rd_q;
  assign acc_num = acc_num_q;
  assign res = res_q;

  wire acc_w = (state_q == sea_pkg::SEA_IDLE) && req.valid;

  property p_local_idx;
    @(posedge clk) disable iff (rst)
    acc_w && !req.ind && !req.remote && req.x != 4'h0 && !idx_global(req.idx_val)
    |=> res.valid && res.ea.sec == $past(req.pc_sec)
        && res.ea.loc == $past(req.y) + $past(req.idx_val[17:0]);
  endproperty
  a_local_idx: assert property (p_local_idx) else $error("local index result wrong");

  property p_wrap_ac;
    @(posedge clk) disable iff (rst)
    res.valid && res.local_ea |-> res.is_ac == (res.ea.loc < 18'h00010);
  endproperty
  a_wrap_ac: assert property (p_wrap_ac) else $error("accumulator mapping wrong");

  property p_global_idx;
    @(posedge clk) disable iff (rst)
    acc_w && !req.ind && req.x != 4'h0 && idx_global(req.idx_val)
    |=> res.valid && !res.local_ea
        && res.ea == $past(req.idx_val[29:0]) + {{12{$past(req.y[17])}}, $past(req.y)};
  endproperty
  a_global_idx: assert property (p_global_idx) else $error("global index sum wrong");

  property p_glob_mem;
    @(posedge clk) disable iff (rst)
    res.valid && !res.local_ea |-> !res.is_ac;
  endproperty
  a_glob_mem: assert property (p_glob_mem) else $error("global address hit accumulators");

  property p_local_ind;
    @(posedge clk) disable iff (rst)
    state_q == sea_pkg::SEA_IND && mem_ack && mem_data[35] && !mem_data[22]
      && mem_data[21:18] == 4'h0
    |=> res.valid && res.ea.sec == $past(base_q) && res.ea.loc == $past(mem_data[17:0]);
  endproperty
  a_local_ind: assert property (p_local_ind) else $error("local indirect section wrong");

  property p_glob_ind;
    @(posedge clk) disable iff (rst)
    state_q == sea_pkg::SEA_IND && mem_ack && !mem_data[35] && !mem_data[34]
      && mem_data[33:30] == 4'h0
    |=> res.valid && res.ea == $past(mem_data[29:0]);
  endproperty
  a_glob_ind: assert property (p_glob_ind) else $error("global indirect target wrong");

  property p_remote;
    @(posedge clk) disable iff (rst)
    acc_w && req.remote && !req.ind && req.x == 4'h0
    |=> res.valid && res.ea.sec == $past(req.fetch_sec) ##1 !res.valid;
  endproperty
  a_remote: assert property (p_remote) else $error("remote section wrong");

  property p_jsave;
    @(posedge clk) disable iff (rst)
    acc_w && req.jump_save && !req.ind
    |=> res.jump_save && res.save_pc.sec == $past(req.pc_sec)
        && res.save_pc.loc == $past(req.pc_loc) + 18'h00001;
  endproperty
  a_jsave: assert property (p_jsave) else $error("saved PC wrong");

  property p_glob_ind_idx;
    @(posedge clk) disable iff (rst)
    state_q == sea_pkg::SEA_ACC && pglob_q && !pind_q
    |-> acc_rd ##1 res.valid && res.ea == $past(pg_q) + $past(acc_data[29:0]);
  endproperty
  a_glob_ind_idx: assert property (p_glob_ind_idx) else $error("indexed global indirect wrong");
endmodule : sea_unit

// >>> testbench/sea_mem_model.sv
`timescale 1ns/10ps
module sea_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_rd,
  output logic mem_ack,
  output logic [35:0] mem_data,
  input wire logic acc_rd,
  input wire logic [3:0] acc_num,
  output logic [35:0] acc_data,
  input wire logic [35:0] word,
  input wire logic [35:0] acc_word,
  input wire logic [3:0] lat
);
  logic pend_q;
  logic [3:0] cnt_q;
  // Wrong register number changes the operand, so a bad acc_num shows in the result
  assign acc_data = acc_rd ? {acc_word[35:4], acc_word[3:0] ^ acc_num} : ~acc_word;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pend_q <= 1'b0;
      cnt_q <= 4'h0;
      mem_ack <= 1'b0;
      mem_data <= 36'h0;
    end
    else
    begin
      mem_ack <= 1'b0;
      // Data line scrambled outside the ack cycle
      mem_data <= ~mem_data;
      if (mem_rd)
      begin
        pend_q <= 1'b1;
        cnt_q <= lat;
      end
      else if (pend_q && cnt_q == 4'h0)
      begin
        pend_q <= 1'b0;
        mem_ack <= 1'b1;
        mem_data <= word;
      end
      else if (pend_q)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : sea_mem_model

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk;
  logic rst;
  sea_pkg::sea_req_t req;
  sea_pkg::sea_req_t r;
  sea_pkg::sea_addr_t mem_addr;
  sea_pkg::sea_res_t res;
  logic busy;
  logic mem_rd;
  logic mem_ack;
  logic acc_rd;
  logic [3:0] acc_num;
  logic [3:0] lat;
  logic [35:0] mem_data;
  logic [35:0] acc_data;
  logic [35:0] word;
  logic [35:0] acc_word;
  int n_fail;
  int n_checks;

  sea_unit u_dut (.clk(clk), .rst(rst), .req(req), .busy(busy), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data), .acc_rd(acc_rd),
    .acc_num(acc_num), .acc_data(acc_data), .res(res));
  sea_mem_model u_mem (.clk(clk), .rst(rst), .mem_rd(mem_rd), .mem_ack(mem_ack),
    .mem_data(mem_data), .acc_rd(acc_rd), .acc_num(acc_num), .acc_data(acc_data),
    .word(word), .acc_word(acc_word), .lat(lat));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic sea_pkg::sea_req_t mk(input logic [17:0] y, input logic [3:0] x,
    input logic ind, input logic [35:0] idx);
    sea_pkg::sea_req_t q;
    q = '0;
    q.valid = 1'b1;
    q.y = y;
    q.x = x;
    q.ind = ind;
    q.idx_val = idx;
    q.pc_sec = 12'h012;
    q.pc_loc = 18'h00040;
    return q;
  endfunction : mk

  task automatic run(input sea_pkg::sea_req_t q, input logic [35:0] w,
    input logic [35:0] a, input logic [3:0] l);
    int i;
    while (busy !== 1'b0)
      @(negedge clk);
    @(posedge clk);
    req <= q;
    word <= w;
    acc_word <= a;
    lat <= l;
    @(posedge clk);
    req.valid <= 1'b0;
    for (i = 0; i < 40 && res.valid !== 1'b1; i++)
      @(negedge clk);
    chk({35'h0, res.valid}, 36'h1);
    // Busy must still stand while the result is shown
    chk({35'h0, busy}, 36'h1);
  endtask : run

  task automatic t_local;
    run(mk(18'h3fe00, 4'h3, 1'b0, 36'h000000200), 36'h0, 36'h0, 4'h0);
    chk({6'h0, res.ea}, {18'h012, 18'h00000});
    chk({35'h0, res.is_ac}, 36'h1);
    run(mk(18'h3ffff, 4'h3, 1'b0, 36'h000000011), 36'h0, 36'h0, 4'h0);
    chk({6'h0, res.ea}, {18'h012, 18'h00010});
    run(mk(18'h00200, 4'h3, 1'b0, 36'hffff00040), 36'h0, 36'h0, 4'h0);
    chk({6'h0, res.ea}, {18'h012, 18'h00240});
    $display("test local indexing done");
  endtask : t_local

  task automatic t_global;
    run(mk(18'h00040, 4'h2, 1'b0, 36'h000600200), 36'h0, 36'h0, 4'h0);
    chk({6'h0, res.ea}, {18'h018, 18'h00240});
    run(mk(18'h3fe00, 4'h2, 1'b0, 36'h000600200), 36'h0, 36'h0, 4'h0);
    chk({6'h0, res.ea}, {18'h018, 18'h00000});
    chk({35'h0, res.is_ac}, 36'h0);
    run(mk(18'h3fc00, 4'h2, 1'b0, 36'h000600200), 36'h0, 36'h0, 4'h0);
    chk({6'h0, res.ea}, {18'h017, 18'h3fe00});
    $display("test global indexing done");
  endtask : t_global

  task automatic t_indirect;
    run(mk(18'h00200, 4'h0, 1'b1, 36'h0), 36'h800000040, 36'h0, 4'h0);
    chk({6'h0, mem_addr}, {18'h012, 18'h00200});
    chk({6'h0, res.ea}, {18'h012, 18'h00040});
    chk({35'h0, res.local_ea}, 36'h1);
    run(mk(18'h00200, 4'h0, 1'b1, 36'h0), 36'h000600200, 36'h0, 4'h3);
    chk({6'h0, mem_addr}, {18'h012, 18'h00200});
    chk({6'h0, res.ea}, {18'h018, 18'h00200});
    chk({35'h0, res.local_ea}, 36'h0);
    run(mk(18'h00200, 4'h0, 1'b1, 36'h0), 36'h140600200, 36'h000000045, 4'h1);
    chk({6'h0, res.ea}, {18'h018, 18'h00240});
    // Local indirect word indexed by a local register
    run(mk(18'h00200, 4'h0, 1'b1, 36'h0), 36'h8000c0040, 36'h000000103, 4'h2);
    chk({6'h0, res.ea}, {18'h012, 18'h00140});
    chk({35'h0, res.is_ac}, 36'h0);
    $display("test indirection done");
  endtask : t_indirect

  task automatic t_remote;
    r = mk(18'h00400, 4'h0, 1'b0, 36'h0);
    r.remote = 1'b1;
    r.fetch_sec = 12'h018;
    r.jump_save = 1'b1;
    run(r, 36'h0, 36'h0, 4'h0);
    chk({6'h0, res.ea}, {18'h018, 18'h00400});
    chk({6'h0, res.save_pc}, {18'h012, 18'h00041});
    chk({35'h0, res.jump_save}, 36'h1);
    $display("test remote execution done");
  endtask : t_remote

  initial
  begin
    rst = 1'b1;
    req = '0;
    r = '0;
    word = 36'h0;
    acc_word = 36'h0;
    lat = 4'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_local();
    t_global();
    t_indirect();
    t_remote();
    finish_test();
  end

  // Whole run needs well under 200 cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule : tb_top
